// ### stam_top.sv
// ==========================================
// How it works
// - Control register resets to 40h: non-linear receive on, everything else clear.
// - Control bit 6 drives the receiver non-linear processing enable.
// - Trim bit zero: frame delimiter width picks protocol maximum or minimum.
// - Trim and width both one: SOF/EOF low minus 8, SOF high plus 8.
// - Self-test is armed only while the enable field holds 1001.
// - Revision register is read-only; writes to it change nothing.
// - Aux select resets to zero; high nibble pin A, low nibble pin B.
// - Code 0000 tri-states the pin; 0001 routes that pin's own test DAC.
// - Codes 0010 to 0111 route the six analog sources as current output.
// - 1000 production test, 1001 module clock, 1010 high, 1011 low.
// - Code 1100 drives the transmit-active flag.
// - Code 1101 drives the receive-active flag.
// - Code 1110 drives the subcarrier-detected flag.
// - Code 1111 drives the test-bus bit picked by the bit-select field.
// - Three-bit bit-select field picks one bit of the selected test bus.
module stam_top #(
   parameter logic [7:0] REVISION_ID = 8'h5a // Arbitrary value
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic FRAME_DELIM_WIDTH_SEL,
   input wire logic [2:0] TESTBUS_BIT_PICK,
   input wire logic [7:0] TESTBUS,
   input wire stam_pkg::stam_flags_t FLAGS,
   output logic RX_NONLINEAR_EN,
   output logic SELFTEST_ARMED,
   output logic [1:0] FRAME_DELIM_MODE,
   output logic [3:0] SOF_LOW_ADJ,
   output logic [3:0] SOF_HIGH_ADJ,
   output logic [3:0] EOF_LOW_ADJ,
   output logic AUX_PIN_A_O,
   output logic AUX_PIN_A_OE,
   output logic AUX_PIN_B_O,
   output logic AUX_PIN_B_OE,
   output logic [1:0] AUX_ANALOG_EN,
   output logic [3:0] AUX_A_ANALOG_SRC,
   output logic [3:0] AUX_B_ANALOG_SRC
);

   // ==========================================
   // Parameter checks
   // Every control field must land inside the 8-bit register
   if (stam_pkg::RX_NONLINEAR_BIT > 7 || stam_pkg::FRAME_TRIM_BIT > 7) begin : g_bad_field
      $error("control field outside the register");
   end
   if (stam_pkg::SELFTEST_ARM_CODE == stam_pkg::SELFTEST_OFF_CODE) begin : g_bad_code
      $error("self-test arm code equals the off code");
   end

   // ==========================================
   // Input synchronisers
   // Flags and test bus come from other clock regions
   logic [7:0] tb_m_q, tb_s_q;
   stam_pkg::stam_flags_t fl_m_q, fl_s_q;
   logic [3:0] misc_m_q, misc_s_q;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         tb_m_q <= 8'h00;
         tb_s_q <= 8'h00;
         fl_m_q <= '0;
         fl_s_q <= '0;
         misc_m_q <= 4'h0;
         misc_s_q <= 4'h0;
      end else begin
         tb_m_q <= TESTBUS;
         tb_s_q <= tb_m_q;
         fl_m_q <= FLAGS;
         fl_s_q <= fl_m_q;
         misc_m_q <= {FRAME_DELIM_WIDTH_SEL, TESTBUS_BIT_PICK};
         misc_s_q <= misc_m_q;
      end
   end

   logic width_sel;
   logic [2:0] bit_pick;
   logic tb_bit;
   assign width_sel = misc_s_q[3];
   assign bit_pick = misc_s_q[2:0];
   assign tb_bit = tb_s_q[bit_pick];

   // ==========================================
   // Aux source decode, one per pin
   function automatic logic [3:0] pin_drive(input logic [3:0] code,
                                            input stam_pkg::stam_flags_t f,
                                            input logic tbit);
      // Returns {analog_en, oe, dig}, top bit unused
      logic [3:0] r;
      r = 4'h0;
      case (stam_pkg::stam_src_t'(code))
         stam_pkg::SRC_TRISTATE: r = 4'h0;
         stam_pkg::SRC_DAC: r = 4'h4;
         stam_pkg::SRC_CORR_A, stam_pkg::SRC_CORR_B, stam_pkg::SRC_MIN_LEVEL,
         stam_pkg::SRC_ADC_I, stam_pkg::SRC_ADC_Q, stam_pkg::SRC_ADC_IQ: r = 4'h4;
         stam_pkg::SRC_PROD_TEST: r = 4'h4;
         stam_pkg::SRC_SM_CLOCK: r = {2'b00, 1'b1, f.sm_clock};
         stam_pkg::SRC_HIGH: r = 4'h3;
         stam_pkg::SRC_LOW: r = 4'h2;
         stam_pkg::SRC_TX_ACTIVE: r = {2'b00, 1'b1, f.tx_active};
         stam_pkg::SRC_RX_ACTIVE: r = {2'b00, 1'b1, f.rx_active};
         stam_pkg::SRC_SUBCARRIER: r = {2'b00, 1'b1, f.subcarrier};
         stam_pkg::SRC_TESTBUS_BIT: r = {2'b00, 1'b1, tbit};
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   // ==========================================
   // State update
   stam_pkg::stam_state_t s_q, s_d;
   logic [3:0] drv [2];

   // Index 1 is pin A, index 0 pin B, matching the nibble order
   for (genvar p = 0; p < 2; p++) begin : g_pin
      assign drv[p] = pin_drive(s_q.aux_sel[4*p +: 4], fl_s_q, tb_bit);
   end

   always_comb begin
      s_d = s_q;
      if (WR) begin
         case (ADDR)
            stam_pkg::ADDR_SELFTEST_CONTROL:
               s_d.ctrl = WDATA & stam_pkg::SELFTEST_CONTROL_WMASK;
            stam_pkg::ADDR_AUX_PIN_SELECT: s_d.aux_sel = WDATA;
            default: s_d.ctrl = s_q.ctrl; // Revision and unmapped ignore writes
         endcase
      end
      s_d.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            stam_pkg::ADDR_SELFTEST_CONTROL: s_d.rdata = s_q.ctrl;
            stam_pkg::ADDR_SILICON_REVISION: s_d.rdata = REVISION_ID;
            stam_pkg::ADDR_AUX_PIN_SELECT: s_d.rdata = s_q.aux_sel;
            default: s_d.rdata = 8'h00;
         endcase
      end
      // Pin stages lag the select by one cycle
      s_d.aux_dig = {drv[1][0], drv[0][0]};
      s_d.aux_oe = {drv[1][1], drv[0][1]};
      s_d.aux_ana_en = {drv[1][2], drv[0][2]};
      s_d.aux_a_code = {4'h0, s_q.aux_sel[7:4]};
      s_d.aux_b_code = {4'h0, s_q.aux_sel[3:0]};
      s_d.rx_nonlinear = s_q.ctrl[stam_pkg::RX_NONLINEAR_BIT];
      s_d.selftest_armed = (s_q.ctrl[3:0] == stam_pkg::SELFTEST_ARM_CODE);
      // Mode 0 minimum, 1 maximum, 3 trimmed maximum
      s_d.delim_mode = {s_q.ctrl[stam_pkg::FRAME_TRIM_BIT] & width_sel, width_sel};
      if (s_q.ctrl[stam_pkg::FRAME_TRIM_BIT] && width_sel) begin
         s_d.sof_low_adj = stam_pkg::DELIM_TRIM_CYCLES;
         s_d.sof_high_adj = stam_pkg::DELIM_TRIM_CYCLES;
         s_d.eof_low_adj = stam_pkg::DELIM_TRIM_CYCLES;
      end else begin
         s_d.sof_low_adj = 4'h0;
         s_d.sof_high_adj = 4'h0;
         s_d.eof_low_adj = 4'h0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         s_q <= '0;
         s_q.ctrl <= stam_pkg::SELFTEST_CONTROL_RST;
         s_q.aux_sel <= stam_pkg::AUX_PIN_SELECT_RST;
         s_q.rx_nonlinear <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // Outputs
   assign RDATA = s_q.rdata;
   assign RX_NONLINEAR_EN = s_q.rx_nonlinear;
   assign SELFTEST_ARMED = s_q.selftest_armed;
   assign FRAME_DELIM_MODE = s_q.delim_mode;
   assign SOF_LOW_ADJ = s_q.sof_low_adj; // Subtracted from 11 etu
   assign SOF_HIGH_ADJ = s_q.sof_high_adj; // Added to 2 etu
   assign EOF_LOW_ADJ = s_q.eof_low_adj; // Subtracted from 11 etu
   assign AUX_PIN_A_O = s_q.aux_dig[1];
   assign AUX_PIN_A_OE = s_q.aux_oe[1];
   assign AUX_PIN_B_O = s_q.aux_dig[0];
   assign AUX_PIN_B_OE = s_q.aux_oe[0];
   assign AUX_ANALOG_EN = s_q.aux_ana_en;
   assign AUX_A_ANALOG_SRC = s_q.aux_a_code[3:0];
   assign AUX_B_ANALOG_SRC = s_q.aux_b_code[3:0];

   // ==========================================
   // Checks: register bus
   a_ctrl_reset_val: assert property (@(posedge MCLK) $rose(RST_B) |-> s_q.ctrl == 8'h40)
      else $error("control reset value wrong");
   a_ctrl_write: assert property (@(posedge MCLK) disable iff (!RST_B)
      WR && ADDR == 8'h36 |=> s_q.ctrl == ($past(WDATA) & 8'h6f))
      else $error("control write not masked");
   a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RST_B)
      RD && ADDR == 8'h36 |=> (RDATA & 8'h90) == 8'h00)
      else $error("reserved bits not zero");
   a_ctrl_readback: assert property (@(posedge MCLK) disable iff (!RST_B)
      RD && ADDR == 8'h36 |=> RDATA == $past(s_q.ctrl))
      else $error("control readback wrong");
   a_rev_readonly: assert property (@(posedge MCLK) disable iff (!RST_B)
      RD && ADDR == 8'h37 |=> RDATA == REVISION_ID)
      else $error("revision readback wrong");
   a_rev_nowrite: assert property (@(posedge MCLK) disable iff (!RST_B)
      WR && ADDR == 8'h37 |=> $stable(s_q.ctrl) && $stable(s_q.aux_sel))
      else $error("revision write changed a register");
   a_aux_write: assert property (@(posedge MCLK) disable iff (!RST_B)
      WR && ADDR == 8'h38 |=> s_q.aux_sel == $past(WDATA))
      else $error("aux select write lost");
   a_aux_readback: assert property (@(posedge MCLK) disable iff (!RST_B)
      RD && ADDR == 8'h38 |=> RDATA == $past(s_q.aux_sel))
      else $error("aux select readback wrong");

   // ==========================================
   // Checks: receiver, self-test and frame delimiters
   a_nonlin_follow: assert property (@(posedge MCLK) disable iff (!RST_B)
      WR && ADDR == 8'h36 |-> ##2 RX_NONLINEAR_EN == $past(WDATA[6], 2))
      else $error("non-linear enable not following bit 6");
   a_nonlin_on: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.ctrl[6] |=> RX_NONLINEAR_EN)
      else $error("non-linear enable missing");
   a_selftest_arm: assert property (@(posedge MCLK) disable iff (!RST_B)
      WR && ADDR == 8'h36 |-> ##2 SELFTEST_ARMED == ($past(WDATA[3:0], 2) == 4'h9))
      else $error("self-test arm wrong");
   a_armed_high: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.ctrl[3:0] == 4'h9 |=> SELFTEST_ARMED)
      else $error("self-test not armed");
   a_armed_low: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.ctrl[3:0] != 4'h9 |=> !SELFTEST_ARMED)
      else $error("self-test armed by wrong code");
   a_delim_min: assert property (@(posedge MCLK) disable iff (!RST_B)
      !s_q.ctrl[5] && !width_sel |=> FRAME_DELIM_MODE == 2'b00)
      else $error("delimiter not minimum");
   a_delim_max: assert property (@(posedge MCLK) disable iff (!RST_B)
      !s_q.ctrl[5] && width_sel |=> FRAME_DELIM_MODE == 2'b01)
      else $error("delimiter not maximum");
   a_delim_trim: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.ctrl[5] && width_sel |=> FRAME_DELIM_MODE == 2'b11)
      else $error("delimiter not trimmed");
   a_trim_adjust: assert property (@(posedge MCLK) disable iff (!RST_B)
      FRAME_DELIM_MODE == 2'b11 |-> SOF_LOW_ADJ == 4'h8 && SOF_HIGH_ADJ == 4'h8)
      else $error("trim adjust wrong");
   a_eof_adjust: assert property (@(posedge MCLK) disable iff (!RST_B)
      FRAME_DELIM_MODE == 2'b11 |-> EOF_LOW_ADJ == 4'h8)
      else $error("end delimiter adjust wrong");
   a_adjust_off: assert property (@(posedge MCLK) disable iff (!RST_B)
      FRAME_DELIM_MODE != 2'b11 |-> {SOF_LOW_ADJ, SOF_HIGH_ADJ, EOF_LOW_ADJ} == 12'h000)
      else $error("adjust applied outside trim mode");

   // ==========================================
   // Checks: aux pins
   a_aux_tristate: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'h0 && $stable(s_q.aux_sel) |=> !AUX_PIN_A_OE && !AUX_ANALOG_EN[1])
      else $error("pin A not tri-stated");
   a_b_tristate: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] == 4'h0 |=> !AUX_PIN_B_OE && !AUX_ANALOG_EN[0])
      else $error("pin B not tri-stated");
   a_dac_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'h1 |=> AUX_ANALOG_EN[1] && !AUX_PIN_A_OE)
      else $error("pin A DAC not routed");
   a_dac_b: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] == 4'h1 |=> AUX_ANALOG_EN[0] && !AUX_PIN_B_OE)
      else $error("pin B DAC not routed");
   a_analog_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] inside {[4'h2:4'h8]} |=> AUX_ANALOG_EN[1] && !AUX_PIN_A_OE)
      else $error("pin A analog source not enabled");
   a_analog_b: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] inside {[4'h2:4'h8]} |=> AUX_ANALOG_EN[0] && !AUX_PIN_B_OE)
      else $error("pin B analog source not enabled");
   a_src_copy: assert property (@(posedge MCLK) disable iff (!RST_B)
      1'b1 |=> {AUX_A_ANALOG_SRC, AUX_B_ANALOG_SRC} == $past(s_q.aux_sel))
      else $error("analog source code wrong");
   a_aux_high: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] == 4'ha |=> AUX_PIN_B_OE && AUX_PIN_B_O)
      else $error("pin B not high");
   a_high_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'ha |=> AUX_PIN_A_OE && AUX_PIN_A_O)
      else $error("pin A not high");
   a_low_a: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'hb |=> AUX_PIN_A_OE && !AUX_PIN_A_O)
      else $error("pin A not low");
   a_low_b: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] == 4'hb |=> AUX_PIN_B_OE && !AUX_PIN_B_O)
      else $error("pin B not low");
   a_sm_clock: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'h9 |=> AUX_PIN_A_OE && AUX_PIN_A_O == $past(fl_s_q.sm_clock))
      else $error("module clock not routed");
   a_tx_flag: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'hc |=> AUX_PIN_A_OE && AUX_PIN_A_O == $past(fl_s_q.tx_active))
      else $error("transmit flag not routed");
   a_rx_flag: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] == 4'hd |=> AUX_PIN_B_OE && AUX_PIN_B_O == $past(fl_s_q.rx_active))
      else $error("receive flag not routed");
   a_sub_flag: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'he |=> AUX_PIN_A_OE && AUX_PIN_A_O == $past(fl_s_q.subcarrier))
      else $error("subcarrier flag not routed");
   a_aux_testbit: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[7:4] == 4'hf |=> AUX_PIN_A_O == $past(tb_bit))
      else $error("test bus bit not routed");
   a_testbit_b: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_q.aux_sel[3:0] == 4'hf |=> AUX_PIN_B_OE && AUX_PIN_B_O == $past(tb_bit))
      else $error("test bus bit not routed to pin B");

endmodule

// ### stam_pkg.sv
package stam_pkg;

   // ==========================================
   // Register map
   localparam logic [7:0] ADDR_SELFTEST_CONTROL = 8'h36;
   localparam logic [7:0] ADDR_SILICON_REVISION = 8'h37;
   localparam logic [7:0] ADDR_AUX_PIN_SELECT = 8'h38;

   // ==========================================
   // Reset values and field layout
   localparam logic [7:0] SELFTEST_CONTROL_RST = 8'h40;
   localparam logic [7:0] AUX_PIN_SELECT_RST = 8'h00;
   localparam logic [7:0] SELFTEST_CONTROL_WMASK = 8'h6f;
   localparam int RX_NONLINEAR_BIT = 6;
   localparam int FRAME_TRIM_BIT = 5;
   localparam logic [3:0] SELFTEST_ARM_CODE = 4'h9;
   localparam logic [3:0] SELFTEST_OFF_CODE = 4'h0;

   // ==========================================
   // Frame delimiter trim, carrier cycles
   localparam logic [3:0] DELIM_TRIM_CYCLES = 4'h8;

   // ==========================================
   // Aux source codes
   typedef enum logic [3:0] {
      SRC_TRISTATE = 4'h0, SRC_DAC = 4'h1, SRC_CORR_A = 4'h2, SRC_CORR_B = 4'h3,
      SRC_MIN_LEVEL = 4'h4, SRC_ADC_I = 4'h5, SRC_ADC_Q = 4'h6, SRC_ADC_IQ = 4'h7,
      SRC_PROD_TEST = 4'h8, SRC_SM_CLOCK = 4'h9, SRC_HIGH = 4'ha, SRC_LOW = 4'hb,
      SRC_TX_ACTIVE = 4'hc, SRC_RX_ACTIVE = 4'hd, SRC_SUBCARRIER = 4'he,
      SRC_TESTBUS_BIT = 4'hf
   } stam_src_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] aux_sel;
      logic [7:0] rdata;
      logic [1:0] aux_dig;
      logic [1:0] aux_oe;
      logic [1:0] aux_ana_en;
      logic [7:0] aux_a_code;
      logic [7:0] aux_b_code;
      logic selftest_armed;
      logic rx_nonlinear;
      logic [3:0] sof_low_adj;
      logic [3:0] sof_high_adj;
      logic [3:0] eof_low_adj;
      logic [1:0] delim_mode;
   } stam_state_t;

   typedef struct packed {
      logic tx_active;
      logic rx_active;
      logic subcarrier;
      logic prod_test;
      logic sm_clock;
   } stam_flags_t;

endpackage

// ### tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Bench signals
   localparam logic [7:0] REV = 8'h3c; // Arbitrary value
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic wsel = 1'b0;
   logic [2:0] pick = 3'h3;
   logic [7:0] tbus = 8'h96;
   stam_pkg::stam_flags_t flags = 5'h15;
   logic [7:0] rdata;
   logic nl, armed, a_o, a_oe, b_o, b_oe;
   logic [1:0] mode, ana;
   logic [3:0] sl, sh, el, a_src, b_src;
   int n_mismatch = 0;
   int compares = 0;

   always #50 mclk = ~mclk;

   stam_top #(.REVISION_ID(REV)) dut (.MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .FRAME_DELIM_WIDTH_SEL(wsel), .TESTBUS_BIT_PICK(pick),
      .TESTBUS(tbus), .FLAGS(flags), .RX_NONLINEAR_EN(nl), .SELFTEST_ARMED(armed),
      .FRAME_DELIM_MODE(mode), .SOF_LOW_ADJ(sl), .SOF_HIGH_ADJ(sh), .EOF_LOW_ADJ(el),
      .AUX_PIN_A_O(a_o), .AUX_PIN_A_OE(a_oe), .AUX_PIN_B_O(b_o), .AUX_PIN_B_OE(b_oe),
      .AUX_ANALOG_EN(ana), .AUX_A_ANALOG_SRC(a_src), .AUX_B_ANALOG_SRC(b_src));

   // ==========================================
   // Bus and check helpers
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge mclk) begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
      end
      @(posedge mclk) wr <= 1'b0;
   endtask

   task automatic rchk(string what, logic [7:0] a, logic [7:0] exp);
      @(posedge mclk) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge mclk) rd <= 1'b0;
      #1 chk(what, exp, rdata);
   endtask

   // Derived outputs lag the write; flags pass a synchroniser
   task automatic settle();
      repeat (4) @(posedge mclk);
      #1;
   endtask

   function automatic logic [1:0] pin(logic [3:0] c);
      case (c)
         4'h9: return {1'b1, flags.sm_clock};
         4'ha: return 2'b11;
         4'hb: return 2'b10;
         4'hc: return {1'b1, flags.tx_active};
         4'hd: return {1'b1, flags.rx_active};
         4'he: return {1'b1, flags.subcarrier};
         4'hf: return {1'b1, tbus[pick]};
         default: return 2'b00;
      endcase
   endfunction

   // ==========================================
   // Scenarios
   task automatic t_regs();
      rchk("ctrl_rst", 8'h36, 8'h40);
      rchk("aux_rst", 8'h38, 8'h00);
      chk("nl_rst", 8'h01, {7'h0, nl});
      wreg(8'h36, 8'hff);
      rchk("ctrl_rsv", 8'h36, 8'h6f);
      settle();
      chk("armed_off", 8'h00, {7'h0, armed});
      wreg(8'h36, 8'h09);
      settle();
      chk("armed", 8'h01, {7'h0, armed});
      chk("nl_off", 8'h00, {7'h0, nl});
      wreg(8'h36, 8'h00);
      settle();
      chk("disarm", 8'h00, {7'h0, armed});
      rchk("rev", 8'h37, REV);
      @(posedge mclk);
      #1 chk("rd_stand", 8'h00, rdata);
      wreg(8'h37, ~REV);
      rchk("rev_ro", 8'h37, REV);
      wreg(8'h39, 8'h55);
      rchk("unmapped", 8'h39, 8'h00);
      rchk("aux_keep", 8'h38, 8'h00);
   endtask

   task automatic t_frame();
      wreg(8'h36, 8'h20);
      settle();
      chk("mode_min", 8'h00, {6'h0, mode});
      @(posedge mclk) wsel <= 1'b1;
      settle();
      chk("mode_trim", 8'h03, {6'h0, mode});
      chk("sof_adj", {2{stam_pkg::DELIM_TRIM_CYCLES}}, {sl, sh});
      chk("eof_adj", {4'h0, stam_pkg::DELIM_TRIM_CYCLES}, {4'h0, el});
      wreg(8'h36, 8'h40);
      settle();
      chk("mode_max", 8'h01, {6'h0, mode});
      chk("adj_off", 8'h00, {sl, el});
      @(posedge mclk) wsel <= 1'b0;
      settle();
      chk("mode_min0", 8'h00, {6'h0, mode});
   endtask

   task automatic t_aux();
      logic [3:0] c;
      for (int k = 0; k < 32; k++) begin
         c = k[3:0];
         if (k == 16) begin
            @(posedge mclk) begin
               flags <= ~flags;
               tbus <= ~tbus;
            end
         end
         wreg(8'h38, {c, ~c});
         settle();
         chk("src", {c, ~c}, {a_src, b_src});
         chk("ana", {6'h0, c >= 4'h1 && c <= 4'h8, ~c >= 4'h1 && ~c <= 4'h8}, {6'h0, ana});
         chk("pin_a", {6'h0, pin(c)}, {6'h0, a_oe, a_o});
         chk("pin_b", {6'h0, pin(~c)}, {6'h0, b_oe, b_o});
      end
   endtask

   task automatic t_pick();
      wreg(8'h38, 8'hff);
      for (int p = 0; p < 8; p++) begin
         @(posedge mclk) pick <= p[2:0];
         settle();
         chk("pick_a", {7'h0, tbus[p]}, {7'h0, a_o});
         chk("pick_b", {7'h0, tbus[p]}, {7'h0, b_o});
      end
   endtask

   // Reset in mid-run must bring back the register, pin-enable, self-test armed and non-linear reset values
   task automatic t_reset();
      wreg(8'h36, 8'h29);
      wreg(8'h38, 8'hab);
      settle();
      chk("pre_armed", 8'h01, {7'h0, armed});
      chk("pre_pins", 8'h0c, {4'h0, a_oe, b_oe, ana});
      @(posedge mclk) rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("rst_pins", 8'h00, {4'h0, a_oe, b_oe, ana});
      chk("rst_nl", 8'h01, {7'h0, nl});
      @(posedge mclk) rst_b <= 1'b1;
      rchk("ctrl_rst2", 8'h36, 8'h40);
      rchk("aux_rst2", 8'h38, 8'h00);
      settle();
      chk("armed_rst2", 8'h00, {7'h0, armed});
      chk("nl_rst2", 8'h01, {7'h0, nl});
   endtask

   // ==========================================
   // Verdict
   task automatic stop_test();
      $display("n_mismatch %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      t_regs();
      t_frame();
      t_aux();
      t_pick();
      t_reset();
      stop_test();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #400000;
      n_mismatch++;
      stop_test();
   end
endmodule
